// ==== hdl/bcds_pkg.sv ====
// Shared constants for the byte channel data service and its control unit
package bcds_pkg;
  // ---------------------------------------------------------------
  // Register map of the channel's own registers (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  BASE_OFS    = 8'h04;
  localparam logic [7:0]  STAT_OFS    = 8'h08;
  localparam logic [7:0]  COUNT_OFS   = 8'h0C;
  localparam logic [7:0]  DADDR_OFS   = 8'h10;
  // Control register bits
  localparam int CTRL_HALT   = 0;
  localparam int CTRL_IOEXE  = 1;
  localparam int CTRL_SELINT = 2;
  // Status register bits
  localparam int STAT_IRQ    = 0;
  localparam int STAT_DFO    = 1;
  localparam int STAT_CHAIN  = 2;
  localparam int STAT_BYTE   = 8;
  localparam int STAT_DEV    = 16;
  // ---------------------------------------------------------------
  // Control word layout (big-endian bit n is word bit 31-n)
  // ---------------------------------------------------------------
  localparam int DADDR_W   = 18;
  localparam int CMD_HI    = 29;
  localparam int CMD_LO    = 24;
  localparam int FLAG_HI   = 31;
  localparam int FLAG_LO   = 27;
  localparam int CST_HI    = 23;
  localparam int CST_LO    = 17;
  localparam int CNT_HI    = 16;
  localparam int CMD_DIR   = 0;
  localparam int FLAG_CD   = 4;
  localparam int UCW2_BIT  = 2;
  localparam logic [3:0] CMD_RDBK = 4'hC;
  // Status byte bits (big-endian bit 4 and 5)
  localparam int ST_CHEND  = 3;
  localparam int ST_DEVEND = 2;
  localparam logic [7:0] STOP_BYTE = 8'h00;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
endpackage

// ==== hdl/bcds_io_if.sv ====
// Tagged parallel I/O interface between channel and control unit
`timescale 1ns/1ps
interface bcds_io_if;
  logic [7:0] bus_out;
  logic [7:0] bus_in;
  logic       select_out;
  logic       select_in;
  logic       command_out;
  logic       service_out;
  logic       request_in;
  logic       address_in;
  logic       service_in;
  logic       status_in;
  logic       operational_in;
  modport chan (output bus_out, select_out, command_out, service_out,
                input  bus_in, select_in, request_in, address_in,
                       service_in, status_in, operational_in);
  modport cu   (input  bus_out, select_out, command_out, service_out,
                output bus_in, select_in, request_in, address_in,
                       service_in, status_in, operational_in);
endinterface

// ==== hdl/bcds_chan.sv ====
// Channel end: data service sequencer, storage port and AHB-Lite registers
// Operation
// RULE1 - Control units chain select for priority
// RULE2 - Command bit 7 selects transfer direction
// RULE3 - Accept request only when channel free
// RULE4 - Set device request, then raise select out (the code sets devreq_ff and selo_ff on the same clock edge)
// RULE5 - Address in starts cycle, marks data flow
// RULE6 - Capture device address, fetch first control word
// RULE7 - Load data address and command
// RULE8 - Second word address forces bit 29
// RULE9 - Load flags, status, compressed byte count
// RULE10 - Raise command out after both words
// RULE11 - Latch service in byte into data register
// RULE12 - Store byte into lane if count nonzero
// RULE13 - Read forward: count down, address up
// RULE14 - Count zero with chain flag sets control
// RULE15 - Service out acknowledges stored byte
// RULE16 - Operational in drop stores both words
// RULE17 - Read backward decrements data address
// RULE18 - Write sends storage byte on bus out
// RULE19 - Write updates count, address, then stores
// RULE20 - Zero count sends stop command out
// RULE21 - Control unit may end unprompted
// RULE22 - Status byte bit meanings
// RULE23 - Channel or device end requests interrupt
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module bcds_chan
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  bcds_io_if.chan          io,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             irq_req,
  output logic             stor_req,
  output logic             stor_we,
  output logic [3:0]       stor_be,
  output logic [31:0]      stor_addr,
  output logic [31:0]      stor_wdata,
  input  wire logic        stor_ack,
  input  wire logic [31:0] stor_rdata
);
  typedef enum {S_IDLE, S_SEL, S_F1, S_F2, S_CMD, S_WAIT, S_RD, S_WR,
                S_SO, S_STOP, S_END, S_S1, S_S2} bcds_st_t;
  localparam int SW = 13;
  bcds_st_t              st_ff;
  logic [SW-1:0]         s1_ff, s2_ff;
  logic [7:0]            bin;
  logic                  rq_in, ad_in, sv_in, su_in, op_in;
  localparam int DADDR_W_L = bcds_pkg::DADDR_W;
  logic [DADDR_W_L-1:0]  daddr_ff;
  logic [5:0]            cmd_ff;
  logic [4:0]            flags_ff;
  logic [6:0]            cst_ff;
  logic [17:0]           count_ff;
  logic [7:0]            dev_ff, data_ff, last_st_ff;
  logic                  dfo_ff, devreq_ff, chain_ff, irq_ff;
  logic [2:0]            ctrl_ff;
  logic [31:0]           base_ff;
  logic                  wr_pend_ff;
  logic [7:0]            wr_ofs_ff;
  logic                  hrdy_ff;
  logic [31:0]           hrdata_ff;
  logic                  selo_ff, cmdo_ff, svco_ff, sreq_ff, swe_ff;
  logic [7:0]            bout_ff;
  logic [3:0]            sbe_ff;
  logic [31:0]           saddr_ff, swd_ff;
  logic                  free, addr_ph, cnt_zero, is_wr, is_bk;
  logic [31:0]           ucw1;

  // Big-endian byte lane of a data address
  function automatic logic [3:0] lane_be(input logic [1:0] a);
    lane_be = 4'h8 >> a;
  endfunction

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  // Two flops on every interface input except select_in
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
    end
    else
    begin
      s1_ff <= {io.bus_in, io.request_in, io.address_in, io.service_in,
                io.status_in, io.operational_in};
      s2_ff <= s1_ff;
    end
  end
  assign {bin, rq_in, ad_in, sv_in, su_in, op_in} = s2_ff;

  // Decode helpers
  assign free     = !dfo_ff && !ctrl_ff[bcds_pkg::CTRL_IOEXE]
                    && !ctrl_ff[bcds_pkg::CTRL_SELINT]; // RULE3
  assign cnt_zero = (count_ff == '0);
  assign is_wr    = cmd_ff[bcds_pkg::CMD_DIR]; // RULE2
  assign is_bk    = (cmd_ff[3:0] == bcds_pkg::CMD_RDBK);
  assign ucw1     = base_ff + {21'h0, dev_ff, 3'h0};

  // ---------------------------------------------------------------
  // Sequencer, tags and storage port
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff <= S_IDLE;
      {selo_ff, cmdo_ff, svco_ff, sreq_ff, swe_ff} <= 5'h00;
      {devreq_ff, dfo_ff} <= 2'h0;
      bout_ff <= 8'h00;
      sbe_ff <= 4'h0;
      saddr_ff <= 32'h0000_0000;
      swd_ff <= 32'h0000_0000;
    end
    else
    begin
      if (stor_ack)
        sreq_ff <= 1'b0;
      case (st_ff)
        S_IDLE:
          if (rq_in && free)
          begin
            devreq_ff <= 1'b1; // RULE4
            selo_ff <= 1'b1; // RULE4
            st_ff <= S_SEL;
          end
        S_SEL:
          if (ad_in)
          begin
            dfo_ff <= 1'b1; // RULE5
            selo_ff <= 1'b0;
            saddr_ff <= base_ff + {21'h0, bin, 3'h0}; // RULE6
            {sreq_ff, swe_ff, sbe_ff} <= {2'b10, 4'hF};
            st_ff <= S_F1;
          end
        S_F1:
          if (stor_ack)
          begin
            saddr_ff <= ucw1 | (32'h1 << bcds_pkg::UCW2_BIT); // RULE8
            sreq_ff <= 1'b1;
            st_ff <= S_F2;
          end
        S_F2:
          if (stor_ack)
          begin
            cmdo_ff <= 1'b1; // RULE10
            bout_ff <= {2'b00, cmd_ff};
            st_ff <= S_CMD;
          end
        S_CMD:
          if (!ad_in)
          begin
            cmdo_ff <= 1'b0;
            st_ff <= S_WAIT;
          end
        S_WAIT:
          if (sv_in && cnt_zero && !flags_ff[bcds_pkg::FLAG_CD])
          begin
            cmdo_ff <= 1'b1; // RULE20
            bout_ff <= bcds_pkg::STOP_BYTE; // RULE20
            st_ff <= S_STOP;
          end
          else if (sv_in && is_wr)
          begin
            saddr_ff <= {14'h0, daddr_ff[17:2], 2'b00}; // RULE18
            {sreq_ff, swe_ff, sbe_ff} <= {2'b10, 4'hF};
            st_ff <= S_WR;
          end
          else if (sv_in && !cnt_zero && !ctrl_ff[bcds_pkg::CTRL_HALT])
          begin
            saddr_ff <= {14'h0, daddr_ff[17:2], 2'b00}; // RULE12
            {sreq_ff, swe_ff} <= 2'b11;
            sbe_ff <= lane_be(daddr_ff[1:0]); // RULE12
            swd_ff <= {4{bin}};
            st_ff <= S_RD;
          end
          else if (sv_in || su_in)
          begin
            svco_ff <= 1'b1;
            st_ff <= S_SO;
          end
          else if (!op_in)
          begin
            st_ff <= S_END;
          end
        S_RD:
          if (stor_ack)
          begin
            svco_ff <= 1'b1; // RULE15
            st_ff <= S_SO;
          end
        S_WR:
          if (stor_ack)
          begin
            bout_ff <= stor_rdata[8*(3-daddr_ff[1:0]) +: 8]; // RULE18
            svco_ff <= 1'b1; // RULE18
            st_ff <= S_SO;
          end
        S_SO:
          if (!sv_in && !su_in)
          begin
            svco_ff <= 1'b0;
            st_ff <= S_END;
          end
        S_STOP:
          if (!sv_in)
          begin
            cmdo_ff <= 1'b0;
            st_ff <= S_END;
          end
        S_END:
          if (!op_in)
          begin
            saddr_ff <= ucw1; // RULE16 RULE19
            swd_ff <= {2'b00, cmd_ff, 6'h00, daddr_ff};
            {sreq_ff, swe_ff, sbe_ff} <= {2'b11, 4'hF};
            st_ff <= S_S1;
          end
        S_S1:
          if (stor_ack)
          begin
            saddr_ff <= ucw1 | (32'h1 << bcds_pkg::UCW2_BIT); // RULE16
            swd_ff <= {flags_ff, 3'h0, cst_ff[6:1],
                       cst_ff[0] | count_ff[17], count_ff[16:0]};
            sreq_ff <= 1'b1;
            st_ff <= S_S2;
          end
        S_S2:
          if (stor_ack)
          begin
            {devreq_ff, dfo_ff, swe_ff} <= 3'h0;
            st_ff <= S_IDLE;
          end
        default:
          st_ff <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Subchannel datapath
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      daddr_ff <= '0;
      {cmd_ff, flags_ff, cst_ff} <= '0;
      count_ff <= '0;
      {dev_ff, data_ff, last_st_ff} <= '0;
      {chain_ff, irq_ff} <= 2'h0;
    end
    else
    begin
      if (st_ff == S_SEL && ad_in)
        dev_ff <= bin; // RULE6
      if (st_ff == S_F1 && stor_ack)
      begin
        daddr_ff <= stor_rdata[DADDR_W_L-1:0]; // RULE7
        cmd_ff <= stor_rdata[bcds_pkg::CMD_HI:bcds_pkg::CMD_LO]; // RULE7
      end
      if (st_ff == S_F2 && stor_ack)
      begin
        flags_ff <= stor_rdata[bcds_pkg::FLAG_HI:bcds_pkg::FLAG_LO]; // RULE9
        cst_ff <= stor_rdata[bcds_pkg::CST_HI:bcds_pkg::CST_LO]; // RULE9
        count_ff <= {|stor_rdata[bcds_pkg::CST_HI:bcds_pkg::CST_LO],
                     stor_rdata[bcds_pkg::CNT_HI:0]}; // RULE9
      end
      if (st_ff == S_WAIT && sv_in && !is_wr)
        data_ff <= bin; // RULE11
      if (st_ff == S_WR && stor_ack)
        data_ff <= stor_rdata[8*(3-daddr_ff[1:0]) +: 8];
      // Software clears first, so a set in the same cycle wins
      if (wr_pend_ff && wr_ofs_ff == bcds_pkg::STAT_OFS)
      begin
        if (hwdata[bcds_pkg::STAT_IRQ])
          irq_ff <= 1'b0;
        if (hwdata[bcds_pkg::STAT_CHAIN])
          chain_ff <= 1'b0;
      end
      if ((st_ff == S_RD || st_ff == S_WR) && stor_ack)
      begin
        count_ff <= count_ff - 18'h1; // RULE13 RULE19
        if (is_bk && !is_wr)
          daddr_ff <= daddr_ff - 18'h1; // RULE17
        else
          daddr_ff <= daddr_ff + 18'h1; // RULE13 RULE19
        if (count_ff == 18'h1 && flags_ff[bcds_pkg::FLAG_CD])
          chain_ff <= 1'b1; // RULE14
      end
      if (st_ff == S_WAIT && su_in && !sv_in)
      begin
        last_st_ff <= bin;
        if (bin[bcds_pkg::ST_CHEND] || bin[bcds_pkg::ST_DEVEND])
          irq_ff <= 1'b1; // RULE22 RULE23
      end
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  assign addr_ph = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_ofs_ff <= 8'h00;
      hrdy_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
      ctrl_ff <= 3'h0;
      base_ff <= bcds_pkg::BASE_RST;
    end
    else
    begin
      wr_pend_ff <= addr_ph && hwrite;
      wr_ofs_ff <= haddr[7:0];
      if (wr_pend_ff && wr_ofs_ff == bcds_pkg::CTRL_OFS)
        ctrl_ff <= hwdata[2:0];
      if (wr_pend_ff && wr_ofs_ff == bcds_pkg::BASE_OFS)
        base_ff <= hwdata;
      if (addr_ph && !hwrite)
        case (haddr[7:0])
          bcds_pkg::CTRL_OFS:  hrdata_ff <= {29'h0, ctrl_ff};
          bcds_pkg::BASE_OFS:  hrdata_ff <= base_ff;
          bcds_pkg::STAT_OFS:  hrdata_ff <= {8'h00, dev_ff, last_st_ff,
                                             5'h00, chain_ff, dfo_ff, irq_ff};
          bcds_pkg::COUNT_OFS: hrdata_ff <= {14'h0, count_ff};
          bcds_pkg::DADDR_OFS: hrdata_ff <= {14'h0, daddr_ff};
          default:             hrdata_ff <= 32'h0000_0000;
        endcase
    end
  end

  // Outputs straight from flops, except hresp tied low
  assign hreadyout      = hrdy_ff;
  assign hrdata         = hrdata_ff;
  assign hresp          = 1'b0;
  assign irq_req        = irq_ff;
  assign io.select_out  = selo_ff;
  assign io.command_out = cmdo_ff;
  assign io.service_out = svco_ff;
  assign io.bus_out     = bout_ff;
  assign stor_req       = sreq_ff;
  assign stor_we        = swe_ff;
  assign stor_be        = sbe_ff;
  assign stor_addr      = saddr_ff;
  assign stor_wdata     = swd_ff;
endmodule

// ==== hdl/bcds_cu.sv ====
// Control unit end: requests service, moves bytes, presents status
`timescale 1ns/1ps
module bcds_cu
#(
  parameter logic [7:0] DEV_ADDR  = 8'h01,
  parameter bit         SEL_THRU  = 1'b0
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  bcds_io_if.cu            io,
  input  wire logic        cu_want,
  input  wire logic [7:0]  cu_tx_byte,
  input  wire logic        cu_end,
  input  wire logic [7:0]  cu_status,
  output logic [7:0]       cu_rx_byte,
  output logic             cu_rx_valid,
  output logic             cu_busy
);
  typedef enum {C_IDLE, C_REQ, C_ADDR, C_DATA, C_STAT, C_DROP} bcds_cst_t;
  bcds_cst_t   st_ff;
  logic [10:0] s1_ff, s2_ff;
  logic [7:0]  bo;
  logic        sel, cmd, svc;
  logic        pend_ff, reqi_ff, adi_ff, svi_ff, sti_ff, opi_ff, seli_ff;
  logic [7:0]  bin_ff, stat_ff, rx_ff;
  logic        rxv_ff;

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
    end
    else
    begin
      s1_ff <= {io.bus_out, io.select_out, io.command_out, io.service_out};
      s2_ff <= s1_ff;
    end
  end
  assign {bo, sel, cmd, svc} = s2_ff;

  // ---------------------------------------------------------------
  // Tag sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff <= C_IDLE;
      {pend_ff, reqi_ff, adi_ff, svi_ff, sti_ff, opi_ff, seli_ff} <= 7'h00;
      {bin_ff, stat_ff, rx_ff} <= '0;
      rxv_ff <= 1'b0;
    end
    else
    begin
      rxv_ff <= 1'b0;
      seli_ff <= SEL_THRU ? sel : 1'b0; // RULE1
      if (cu_end && !pend_ff)
      begin
        pend_ff <= 1'b1; // RULE21
        stat_ff <= cu_status;
      end
      case (st_ff)
        C_IDLE:
          if (cu_want || pend_ff)
          begin
            reqi_ff <= 1'b1;
            st_ff <= C_REQ;
          end
        C_REQ:
          if (sel && !SEL_THRU)
          begin
            {reqi_ff, adi_ff, opi_ff} <= 3'b011; // RULE5
            bin_ff <= DEV_ADDR; // RULE5
            st_ff <= C_ADDR;
          end
        C_ADDR:
          if (cmd)
          begin
            adi_ff <= 1'b0;
            bin_ff <= pend_ff ? stat_ff : cu_tx_byte; // RULE11 RULE22
            st_ff <= pend_ff ? C_STAT : C_DATA;
          end
        C_DATA:
          if (svi_ff && cmd)
          begin
            svi_ff <= 1'b0; // RULE20
            pend_ff <= 1'b1; // RULE20
            stat_ff <= 8'h08;
            st_ff <= C_DROP;
          end
          else if (svi_ff && svc)
          begin
            svi_ff <= 1'b0;
            rx_ff <= bo;
            rxv_ff <= 1'b1;
            st_ff <= C_DROP;
          end
          else if (!cmd)
            svi_ff <= 1'b1; // RULE11
        C_STAT:
          if (!cmd && !sti_ff)
            sti_ff <= 1'b1;
          else if (svc)
          begin
            {sti_ff, pend_ff} <= 2'b00;
            st_ff <= C_DROP;
          end
        C_DROP:
          if (!svc && !cmd)
          begin
            opi_ff <= 1'b0; // RULE16
            st_ff <= C_IDLE;
          end
        default:
          st_ff <= C_IDLE;
      endcase
    end
  end

  // Outputs straight from flops
  assign io.bus_in         = bin_ff;
  assign io.request_in     = reqi_ff;
  assign io.address_in     = adi_ff;
  assign io.service_in     = svi_ff;
  assign io.status_in      = sti_ff;
  assign io.operational_in = opi_ff;
  assign io.select_in      = seli_ff;
  assign cu_rx_byte        = rx_ff;
  assign cu_rx_valid       = rxv_ff;
  assign cu_busy           = opi_ff;
endmodule

// ==== tb/bcds_asserts.sv ====
// Checker for the tagged link between channel and control unit
`timescale 1ns/1ps
module bcds_asserts
(
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic [7:0] bus_out,
  input wire logic [7:0] bus_in,
  input wire logic       select_out,
  input wire logic       select_in,
  input wire logic       command_out,
  input wire logic       service_out,
  input wire logic       request_in,
  input wire logic       address_in,
  input wire logic       service_in,
  input wire logic       status_in,
  input wire logic       operational_in
);
  default clocking dcb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ------------------------------------------------------------
  // Selection steps
  // ------------------------------------------------------------
  sequence s_sel_rise;
    $rose(select_out);
  endsequence

  sequence s_addr_back;
    ##[1:12] address_in;
  endsequence

  // ------------------------------------------------------------
  // Link properties
  // ------------------------------------------------------------
  a_sel_on_req: assert property (s_sel_rise |-> $past(request_in))
    else $error("select out without request in");
  a_sel_free: assert property (s_sel_rise |-> !$past(operational_in))
    else $error("select out while unit operational");
  a_sel_answer: assert property (s_sel_rise |-> s_addr_back)
    else $error("no address in after select out");
  a_sel_hold: assert property (select_out && !address_in |=> select_out)
    else $error("select out dropped early");
  a_cmd_in_op: assert property ($rose(command_out) |-> operational_in)
    else $error("command out outside an operation");
  a_stop_zero: assert property
    ($rose(command_out) && service_in |-> bus_out == 8'h00)
    else $error("stop command not zero");
  a_svc_cause: assert property
    ($rose(service_out) |-> service_in || status_in)
    else $error("service out without service in");
  a_svc_hold: assert property (service_out && service_in |=> service_out)
    else $error("service out dropped early");
  a_wr_steady: assert property
    (service_out && $past(service_out) |-> $stable(bus_out))
    else $error("bus out moved under service out");
  a_cmd_steady: assert property
    (command_out && $past(command_out) |-> $stable(bus_out))
    else $error("bus out moved under command out");
endmodule

// ==== tb/tb_byte_channel_data_service.sv ====
// Self-checking bench: channel and control unit joined by the link
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; \
  if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
module tb_byte_channel_data_service;
  typedef struct packed {
    logic [5:0]  cmd;
    logic [17:0] da;
    logic [7:0]  b;
    logic [17:0] exp_da;
  } bcds_row_t;
  localparam logic [31:0] WR_WORD = 32'h8142_C3E7;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, w;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        irq_req, stor_req, stor_we, stor_ack;
  logic [3:0]  stor_be;
  logic [31:0] stor_addr, stor_wdata, stor_rdata;
  logic        cu_want, cu_end, cu_rx_valid, cu_busy;
  logic [7:0]  cu_tx_byte, cu_status, cu_rx_byte, rx_got;
  logic [31:0] mem [256];
  int          num_errors, samples_checked;
  bcds_row_t   rows [5] = '{'{6'h02, 18'h200, 8'hA5, 18'h201},
    '{6'h02, 18'h207, 8'h3C, 18'h208}, '{6'h0C, 18'h20D, 8'h5A, 18'h20C},
    '{6'h01, 18'h212, 8'hC3, 18'h213}, '{6'h01, 18'h210, 8'h81, 18'h211}};

  bcds_io_if io ();
  assign hready = hreadyout;
  // ------------------------------------------------------------
  // Design ends and checker
  // ------------------------------------------------------------
  bcds_chan bcds_chan_i (.hclk(hclk), .hresetn(hresetn), .io(io),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .irq_req(irq_req), .stor_req(stor_req), .stor_we(stor_we),
    .stor_be(stor_be), .stor_addr(stor_addr), .stor_wdata(stor_wdata),
    .stor_ack(stor_ack), .stor_rdata(stor_rdata));
  bcds_cu bcds_cu_i (.hclk(hclk), .hresetn(hresetn), .io(io),
    .cu_want(cu_want), .cu_tx_byte(cu_tx_byte), .cu_end(cu_end),
    .cu_status(cu_status), .cu_rx_byte(cu_rx_byte),
    .cu_rx_valid(cu_rx_valid), .cu_busy(cu_busy));
  bcds_asserts bcds_asserts_i (.hclk(hclk), .hresetn(hresetn),
    .bus_out(io.bus_out), .bus_in(io.bus_in), .select_out(io.select_out),
    .select_in(io.select_in), .command_out(io.command_out),
    .service_out(io.service_out), .request_in(io.request_in),
    .address_in(io.address_in), .service_in(io.service_in),
    .status_in(io.status_in), .operational_in(io.operational_in));

  // Clock
  always #20 hclk = ~hclk;

  // Storage: one-cycle acknowledge, data scrambled when idle
  always @(posedge hclk)
  begin
    stor_ack   <= 1'b0;
    stor_rdata <= ~stor_rdata;
    if (stor_req && !stor_ack)
    begin
      stor_ack   <= 1'b1;
      stor_rdata <= mem[stor_addr[9:2]];
      if (stor_we)
        for (int k = 0; k < 4; k++)
          if (stor_be[k])
            mem[stor_addr[9:2]][8*k +: 8] <= stor_wdata[8*k +: 8];
    end
  end

  // Last byte handed to the control unit
  always @(posedge hclk)
    if (cu_rx_valid === 1'b1)
      rx_got <= cu_rx_byte;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic logic [7:0] lane(input logic [31:0] x, input int a);
    return 8'(x >> (8 * (3 - a)));
  endfunction

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (cu_busy !== lvl && n < 400)
    begin
      @(posedge hclk);
      n++;
    end
    `CHK(cu_busy, lvl)
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      ahb(1'b0, bcds_pkg::STAT_OFS, 32'h0, rd);
      n++;
    end
    while (rd[bcds_pkg::STAT_DFO] !== 1'b0 && n < 100);
    `CHK(rd[bcds_pkg::STAT_DFO], 1'b0)
  endtask

  task automatic wait_irq(input logic [7:0] st);
    int n;
    n = 0;
    while (irq_req !== 1'b1 && n < 600)
    begin
      @(posedge hclk);
      n++;
    end
    `CHK(irq_req, 1'b1)
    wait_idle();
    `CHK(rd[15:8], st)
    ahb(1'b1, bcds_pkg::STAT_OFS, 32'h1, rd);
    #1;
    `CHK(irq_req, 1'b0)
  endtask

  task automatic run_svc(input logic [5:0] cmd, input logic [17:0] da,
                         input logic [7:0] b, input logic [16:0] cnt,
                         input logic [4:0] flg);
    mem[8'h12]   = {2'b00, cmd, 6'h00, da};
    mem[8'h13]   = {flg, 10'h000, cnt};
    mem[da[9:2]] = cmd[0] ? WR_WORD : 32'h0;
    cu_tx_byte <= b;
    cu_want    <= 1'b1;
    wait_busy(1'b1);
    cu_want <= 1'b0;
    wait_busy(1'b0);
    wait_idle();
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    finish_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {hclk, hresetn, hsel, hwrite, cu_want, cu_end} = '0;
    {haddr, hwdata, htrans, cu_tx_byte, cu_status} = '0;
    {stor_ack, stor_rdata, rx_got} = '0;
    hsize = 3'b010;
    num_errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    `CHK(io.select_out, 1'b0)
    `CHK(irq_req, 1'b0)
    ahb(1'b0, 8'h1C, 32'h0, rd);
    `CHK(rd, 32'h0)
    ahb(1'b1, bcds_pkg::BASE_OFS, 32'h40, rd);
    ahb(1'b0, bcds_pkg::BASE_OFS, 32'h0, rd);
    `CHK(rd, 32'h40)
    foreach (rows[i])
    begin
      run_svc(rows[i].cmd, rows[i].da, rows[i].b, 17'd5, 5'h00);
      w = mem[rows[i].da[9:2]];
      `CHK(rows[i].cmd[0] ? rx_got : lane(w, rows[i].da[1:0]), rows[i].b)
      `CHK(mem[8'h12][17:0], rows[i].exp_da)
      `CHK(mem[8'h12][29:24], rows[i].cmd)
      `CHK(mem[8'h13][16:0], 17'd4)
      ahb(1'b0, bcds_pkg::DADDR_OFS, 32'h0, rd);
      `CHK(rd[17:0], rows[i].exp_da)
      ahb(1'b0, bcds_pkg::COUNT_OFS, 32'h0, rd);
      `CHK(rd[17:0], 18'd4)
      ahb(1'b0, bcds_pkg::STAT_OFS, 32'h0, rd);
      `CHK(rd[23:16], 8'h01)
    end
    // Busy channel refuses requests
    for (int k = 1; k < 3; k++)
    begin
      ahb(1'b1, bcds_pkg::CTRL_OFS, 32'h1 << k, rd);
      cu_want <= 1'b1;
      repeat (30) @(posedge hclk);
      `CHK(io.select_out, 1'b0)
    end
    ahb(1'b1, bcds_pkg::CTRL_OFS, 32'h0, rd);
    run_svc(6'h02, 18'h221, 8'h96, 17'd5, 5'h00);
    `CHK(lane(mem[8'h88], 1), 8'h96)
    // Halt suppresses the store
    ahb(1'b1, bcds_pkg::CTRL_OFS, 32'h1, rd);
    run_svc(6'h02, 18'h230, 8'h77, 17'd5, 5'h00);
    `CHK(mem[8'h8C], 32'h0)
    ahb(1'b1, bcds_pkg::CTRL_OFS, 32'h0, rd);
    // Last byte with chain flag
    run_svc(6'h02, 18'h240, 8'h3C, 17'd1, 5'h10);
    ahb(1'b0, bcds_pkg::STAT_OFS, 32'h0, rd);
    `CHK(rd[bcds_pkg::STAT_CHAIN], 1'b1)
    ahb(1'b1, bcds_pkg::STAT_OFS, 32'h4, rd);
    // Zero count: stop, then channel end status
    run_svc(6'h02, 18'h250, 8'h11, 17'd0, 5'h00);
    `CHK(mem[8'h94], 32'h0)
    wait_irq(8'h08);
    // Unit ends by itself with device end
    cu_status <= 8'h04;
    cu_end    <= 1'b1;
    @(posedge hclk);
    cu_end <= 1'b0;
    wait_irq(8'h04);
    finish_test();
  end
endmodule
